// ==== hw/arp_pkg.sv ====
// Package: constants and types of the automatic restart policy block
package arp_pkg;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ARP_MODE_LOCKED    = 3'h0;
  localparam logic [2:0] ARP_MODE_ACK_ON    = 3'h1;
  localparam logic [2:0] ARP_MODE_PF        = 3'h2;
  localparam logic [2:0] ARP_MODE_UV_FLT    = 3'h3;
  localparam logic [2:0] ARP_MODE_UV        = 3'h4;
  localparam logic [2:0] ARP_MODE_PF_FLT    = 3'h5;
  localparam logic [2:0] ARP_MODE_ALL       = 3'h6;

  // ----------------------------------------------------------------
  // Attempt limit
  // ----------------------------------------------------------------
  localparam int         ARP_CNT_W          = 4;
  localparam logic [3:0] ARP_LIMIT_MAX      = 4'ha;
  localparam logic [3:0] ARP_LIMIT_DEFAULT  = 4'h3;
  localparam logic [3:0] ARP_CNT_ZERO       = 4'h0;
  localparam logic [3:0] ARP_CNT_ONE        = 4'h1;

  typedef enum logic [1:0] {
    ARP_ST_RUN,
    ARP_ST_OFF,
    ARP_ST_RETRY,
    ARP_ST_GIVEUP
  } arp_state_t;

endpackage : arp_pkg

// ==== hw/arp_restart.sv ====
// Module: automatic restart decision logic after supply return or fault
//
// Operation
// - Mode 0 never acknowledges faults or restarts; a fresh run command is needed.
// - Mode 1 clears all pending faults once the supply returns after a power failure.
// - Mode 1 never starts by itself; a run command rising after return starts.
// - Modes 1 and 2, and mode 5 unless run was applied unpowered, leave undervoltage faults for manual clearing.
// - Mode 2 clears only the supply-loss fault after a power failure and restarts.
// - Mode 2 starts on a run command applied unpowered only if ready at failure.
// - The attempt limit counts only in modes 3 and 4.
// - A restart interrupted by a new fault is retried up to the limit in mode 3; mode 4 does not retry it.
// - Mode 3 clears all faults and restarts for failure and undervoltage alike.
// - Mode 3 ignores a run command applied unpowered if ready before failure.
// - Mode 4 clears only supply loss and restarts; an unpowered run command is ignored.
// - Mode 5 always restarts on an unpowered run command, clearing all faults in the same cycle.
// - Mode 6 clears all faults and starts on return; an outage run command starts.
// - With run held, faults in operation are cleared and restarted only in modes 3, 6.
`timescale 1ns/100ps
`default_nettype none

module arp_restart
  import arp_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // Settings
  input  wire logic [2:0]            restart_mode_select,
  input  wire logic [arp_pkg::ARP_CNT_W-1:0] restart_attempt_limit,
  // Supply and run command pins
  input  wire logic                  supply_ok,
  input  wire logic                  supply_uv,
  input  wire logic                  run_cmd_di,
  // Fault monitor
  input  wire logic                  fault_pending,
  input  wire logic                  supply_loss_fault,
  input  wire logic                  drive_ready,
  // Actions to the drive core
  output logic                       clear_all_faults,
  output logic                       clear_supply_loss,
  output logic                       drive_start,
  output logic                       retries_exhausted,
  output logic [arp_pkg::ARP_CNT_W-1:0] attempt_count
);
  import arp_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Pins come from outside the clock domain; first stage read only here
  logic [3:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic       sok, suv, run, rdy, run_pin;

  always_comb begin
    sync1_d = {drive_ready, run_cmd_di, supply_uv, supply_ok};
    sync2_d = sync1_q;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  assign sok = sync2_q[0];
  assign suv = sync2_q[1];
  assign run = sync2_q[2] & sync2_q[0];
  assign rdy = sync2_q[3];
  // Raw pin level, only to see a run applied while unpowered
  assign run_pin = sync2_q[2];

  // ----------------------------------------------------------------
  // Policy state
  // ----------------------------------------------------------------
  arp_state_t             st_q, st_d;
  logic                   uv_q, uv_d;        // outage was undervoltage
  logic                   rdy_q, rdy_d;      // ready when power failed
  logic                   flt_q, flt_d;      // fault pending at failure
  logic                   onoff_q, onoff_d;  // run applied while unpowered
  logic                   sok_q, run_q, runp_q;
  logic [ARP_CNT_W-1:0]   cnt_q, cnt_d;
  logic                   clr_all_d, clr_sl_d, start_d;
  logic                   clr_all_q, clr_sl_q, start_q;
  logic                   limited, ret_edge, run_rise, cnt_ok;
  logic [ARP_CNT_W-1:0]   lim;

  always_comb begin
    // Out-of-range limit is clipped rather than trusted
    lim = (restart_attempt_limit > ARP_LIMIT_MAX) ? ARP_LIMIT_MAX
                                                  : restart_attempt_limit;
    limited  = (restart_mode_select == ARP_MODE_UV_FLT) ||
               (restart_mode_select == ARP_MODE_UV);
    cnt_ok   = !limited || (cnt_q < lim);
    ret_edge = sok & ~sok_q;
    run_rise = run & ~run_q;
    st_d      = st_q;
    uv_d      = uv_q;
    rdy_d     = rdy_q;
    flt_d     = flt_q;
    onoff_d   = onoff_q;
    cnt_d     = cnt_q;
    clr_all_d = 1'b0;
    clr_sl_d  = 1'b0;
    start_d   = 1'b0;
    unique case (st_q)
      ARP_ST_RUN: begin
        if (!sok) begin
          st_d    = ARP_ST_OFF;
          uv_d    = suv;
          rdy_d   = rdy;
          // Supply loss latches before the outage is seen; only other
          // faults count here (a loss plus another fault is missed)
          flt_d   = fault_pending && !supply_loss_fault;
          onoff_d = 1'b0;
        end else if (fault_pending && run && !clr_all_q && !clr_sl_q) begin
          // The cycle after a clear still shows the old fault: skipped
          // Faults raised in operation
          if ((restart_mode_select == ARP_MODE_UV_FLT) ||
              (restart_mode_select == ARP_MODE_ALL)) begin
            if (cnt_ok) begin
              clr_all_d = 1'b1;
              st_d      = ARP_ST_RETRY;
              if (limited)
                cnt_d = cnt_q + ARP_CNT_ONE;
            end else begin
              st_d = ARP_ST_GIVEUP;
            end
          end
        end else if (!fault_pending && run_rise && rdy) begin
          start_d = 1'b1;  // Ordinary start by the run command
        end
      end
      ARP_ST_OFF: begin
        if (!runp_q && run_pin)
          onoff_d = 1'b1;
        if (ret_edge) begin
          st_d = ARP_ST_RUN;
          unique case (restart_mode_select)
            ARP_MODE_ACK_ON:
              clr_all_d = !uv_q;
            ARP_MODE_PF: begin
              clr_sl_d = !uv_q && supply_loss_fault;
              start_d  = !uv_q && run && (!onoff_q || rdy_q);
            end
            ARP_MODE_UV_FLT: begin
              // Failure and undervoltage treated alike
              clr_all_d = 1'b1;
              start_d   = run && !(onoff_q && rdy_q);
            end
            ARP_MODE_UV: begin
              clr_sl_d = supply_loss_fault;
              start_d  = run && !onoff_q && !flt_q;
            end
            ARP_MODE_PF_FLT: begin
              clr_all_d = !uv_q || onoff_q;
              start_d   = run && (!uv_q || onoff_q);
            end
            ARP_MODE_ALL: begin
              clr_all_d = 1'b1;
              start_d   = run;
            end
            default: ;
          endcase
          if (start_d && limited) begin
            if (cnt_ok)
              cnt_d = cnt_q + ARP_CNT_ONE;
            else begin
              start_d   = 1'b0;
              clr_all_d = 1'b0;
              clr_sl_d  = 1'b0;
              st_d      = ARP_ST_GIVEUP;
            end
          end
        end
      end
      ARP_ST_RETRY: begin
        // One cycle after the clear, restart if still commanded
        st_d    = ARP_ST_RUN;
        start_d = run && sok;
      end
      ARP_ST_GIVEUP: begin
        // Latest fault stays pending; run removal rearms the sequence
        if (!run) begin
          st_d  = ARP_ST_RUN;
          cnt_d = ARP_CNT_ZERO;
        end
      end
    endcase
    // A clean run with no fault ends the attempt series
    // Not in the start cycle: a refault only shows one cycle later
    if (st_q == ARP_ST_RUN && sok && run && !fault_pending && rdy &&
        !start_q)
      cnt_d = ARP_CNT_ZERO;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q      <= ARP_ST_RUN;
      uv_q      <= 1'b0;
      rdy_q     <= 1'b0;
      flt_q     <= 1'b0;
      onoff_q   <= 1'b0;
      sok_q     <= 1'b0;
      run_q     <= 1'b0;
      runp_q    <= 1'b0;
      cnt_q     <= ARP_CNT_ZERO;
      clr_all_q <= 1'b0;
      clr_sl_q  <= 1'b0;
      start_q   <= 1'b0;
    end else begin
      st_q      <= st_d;
      uv_q      <= uv_d;
      rdy_q     <= rdy_d;
      flt_q     <= flt_d;
      onoff_q   <= onoff_d;
      sok_q     <= sok;
      run_q     <= run;
      runp_q    <= run_pin;
      cnt_q     <= cnt_d;
      clr_all_q <= clr_all_d;
      clr_sl_q  <= clr_sl_d;
      start_q   <= start_d;
    end
  end

  assign clear_all_faults  = clr_all_q;
  assign clear_supply_loss = clr_sl_q;
  assign drive_start       = start_q;
  assign retries_exhausted = (st_q == ARP_ST_GIVEUP);
  assign attempt_count     = cnt_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_mode0_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (restart_mode_select == ARP_MODE_LOCKED) |=> !clear_all_faults)
    else $error("mode 0 cleared faults");
  a_mode1_no_auto: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_q == ARP_ST_OFF && ret_edge && restart_mode_select == ARP_MODE_ACK_ON)
    |=> !drive_start)
    else $error("mode 1 started on supply return");
  a_mode1_ack: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_q == ARP_ST_OFF && ret_edge && !uv_q &&
     restart_mode_select == ARP_MODE_ACK_ON) |=> clear_all_faults)
    else $error("mode 1 missed acknowledgement");
  a_uv_kept: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_q == ARP_ST_OFF && ret_edge && uv_q && !onoff_q &&
     (restart_mode_select == ARP_MODE_ACK_ON ||
      restart_mode_select == ARP_MODE_PF ||
      restart_mode_select == ARP_MODE_PF_FLT)) |=> !clear_all_faults)
    else $error("undervoltage fault auto cleared");
  a_mode2_only_sl: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (restart_mode_select == ARP_MODE_PF) |=> !clear_all_faults)
    else $error("mode 2 cleared all faults");
  a_mode4_only_sl: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (restart_mode_select == ARP_MODE_UV) |=> !clear_all_faults)
    else $error("mode 4 cleared all faults");
  a_count_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
    limited && $stable(restart_attempt_limit) && cnt_q <= lim
    |=> cnt_q <= lim)
    else $error("attempt count passed the limit");
  a_count_locked: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!limited && $past(!limited)) |-> $stable(cnt_q) || cnt_q == ARP_CNT_ZERO)
    else $error("attempts counted in an unlimited mode");
  a_oper_fault: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_q == ARP_ST_RUN && sok && fault_pending && run &&
     !clr_all_q && !clr_sl_q &&
     restart_mode_select == ARP_MODE_ALL) |=> clear_all_faults ##1
    (drive_start == (run && sok)))
    else $error("mode 6 operation fault not restarted");

  c_mode6_return: cover property (@(posedge ref_clk) disable iff (sys_rst)
    restart_mode_select == ARP_MODE_ALL && ret_edge ##1 drive_start);
  c_retry: cover property (@(posedge ref_clk) disable iff (sys_rst)
    st_q == ARP_ST_RETRY ##1 drive_start);
  c_giveup: cover property (@(posedge ref_clk) disable iff (sys_rst)
    st_q == ARP_ST_GIVEUP);

endmodule : arp_restart

`default_nettype wire

// ==== sim/arp_fault_mon.sv ====
// Fault monitor model standing beside the restart block
`timescale 1ns/100ps
`default_nettype none

module arp_fault_mon (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Bench controls
  input  wire logic supply_ok,
  input  wire logic raise_fault,
  input  wire logic refault,
  input  wire logic ext_ack,
  // Block actions and fault state
  input  wire logic clear_all_faults,
  input  wire logic clear_supply_loss,
  input  wire logic drive_start,
  output logic      fault_pending,
  output logic      supply_loss_fault
);
  logic loss_q;
  logic other_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || ext_ack) begin
      loss_q  <= 1'b0;
      other_q <= 1'b0;
    end else begin
      // Loss fault latches while the supply is gone
      if (!supply_ok) begin
        loss_q <= 1'b1;
      end else if (clear_all_faults || clear_supply_loss) begin
        loss_q <= 1'b0;
      end
      // Refault hits every start, so a restart never runs clean
      if (raise_fault || (refault && drive_start)) begin
        other_q <= 1'b1;
      end else if (clear_all_faults) begin
        other_q <= 1'b0;
      end
    end
  end

  assign fault_pending     = loss_q | other_q;
  assign supply_loss_fault = loss_q;
endmodule : arp_fault_mon

`default_nettype wire

// ==== sim/auto_restart_policy_tb.sv ====
// Self-checking bench of the restart policy block
`timescale 1ns/100ps
`default_nettype none

module auto_restart_policy_tb;
  import arp_pkg::*;
  logic        ref_clk, sys_rst, sup_ok, sup_uv, run, rdy;
  logic        rf, refault, ack, fp, slf, ca, cl, st, ex;
  logic [2:0]  mode;
  logic [3:0]  lim, cnt;
  logic [31:0] lfsr = 32'h332d0a0f;
  int          fail_count = 0;
  int          n_compared = 0;
  int          n_ca, n_cl, n_st;
  // Outcome per mode: bit 2 clear all, bit 1 clear loss, bit 0 start
  int          exp_pf[7] = '{0, 4, 3, 5, 3, 5, 5};
  int          exp_uv[7] = '{0, 0, 0, 5, 3, 0, 5};
  int          exp_de[7] = '{0, 0, 1, 0, 0, 1, 1};

  arp_restart dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .restart_mode_select(mode), .restart_attempt_limit(lim),
    .supply_ok(sup_ok), .supply_uv(sup_uv), .run_cmd_di(run),
    .fault_pending(fp), .supply_loss_fault(slf), .drive_ready(rdy),
    .clear_all_faults(ca), .clear_supply_loss(cl), .drive_start(st),
    .retries_exhausted(ex), .attempt_count(cnt));
  arp_fault_mon fm (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .supply_ok(sup_ok), .raise_fault(rf), .refault(refault),
    .ext_ack(ack), .clear_all_faults(ca), .clear_supply_loss(cl),
    .drive_start(st), .fault_pending(fp), .supply_loss_fault(slf));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Pulses are one cycle wide, so counting edges counts actions
  always @(posedge ref_clk) begin
    n_ca += (ca === 1'b1);
    n_cl += (cl === 1'b1);
    n_st += (st === 1'b1);
  end

  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic chk_n(int got, int exp);
    n_compared++;
    if (got != exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_n

  task automatic chk_v(logic [3:0] got, logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_v

  task automatic print_verdict;
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // Fresh start: faults acknowledged from outside, block reset
  task automatic setup(logic [2:0] m, logic run_v);
    mode    = m;
    run     = 1'b0;
    rf      = 1'b0;
    refault = 1'b0;
    ack     = 1'b1;
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    ack     = 1'b0;
    tick(4);
    run     = run_v;
    tick(10);
  endtask : setup

  task automatic outage(logic uv, logic de);
    sup_ok = 1'b0;
    sup_uv = uv;
    tick(10);
    run = run | de;
    tick(6);
    n_ca = 0;
    n_cl = 0;
    n_st = 0;
    sup_ok = 1'b1;
    tick(20);
  endtask : outage

  initial begin
    int e;
    sys_rst = 1'b1;
    {mode, sup_uv, run, rf, refault, ack} = '0;
    {sup_ok, rdy} = 2'b11;
    lim = ARP_LIMIT_DEFAULT;
    tick(5);
    for (int m = 0; m < 7; m++) begin
      // Power failure, undervoltage, run applied while unpowered
      for (int k = 0; k < 3; k++) begin
        setup(m[2:0], k != 2);
        outage(k == 1, k == 2);
        if (k == 2) begin
          chk_n(n_st, exp_de[m]);
        end else begin
          e = (k == 1) ? exp_uv[m] : exp_pf[m];
          chk_n(n_ca, e[2]);
          chk_n(n_cl, e[1]);
          chk_n(n_st, e[0]);
        end
      end
      // Fault in operation, every restart broken by a new fault
      lfsr = lfsr_next(lfsr);
      lim  = {2'b00, lfsr[1:0]} % 4'h3 + 4'h1;
      setup(m[2:0], 1'b1);
      refault = 1'b1;
      n_st = 0;
      rf = 1'b1;
      tick(1);
      rf = 1'b0;
      tick(60);
      if (m == 3) begin
        chk_n(n_st, int'(lim));
        chk_v(cnt, lim);
        chk_v({3'h0, ex}, 4'h1);
      end else begin
        chk_n(int'(n_st > 0), int'(m == 6));
        chk_v(cnt, 4'h0);
        chk_v({3'h0, ex}, 4'h0);
      end
    end
    print_verdict();
  end
endmodule : auto_restart_policy_tb

`default_nettype wire
